// ### verilog/nvls_engine.sv
// NV register load/store engine serving two program threads.
// Assumes a register file read combinationally from rf_idx while
// rf_rd_req is high, and an NV array answering each request by nv_ack.
//
// Overview of operation
// - Single load reads NV word pair, checks checksum, writes only writable
// - NV address zero takes the real address from register ten
// - Negative register keeps program running; zero or negative flag set
// - One thread owns NV memory at a time; the other waits
// - Multi store copies 1 to 10 registers plus one checksum word
// - Each register goes out as two 16-bit writes, resampled between
// - Protected NV write raises command error and status bits 12, 14
// - Single store writes one register with its own checksum
// - Buffer-long write puts a register into two buffer words
// - Buffer writes carry no range check on the value
// - Load checksum mismatch sets status bits 14 and 12
`timescale 1ns/1ps
`default_nettype none
`include "nvls_regs.svh"
module nvls_engine
    import nvls_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] cmd_valid,
    input wire nvls_cmd_s cmd0,
    input wire nvls_cmd_s cmd1,
    output logic [1:0] cmd_ack,
    output logic cmd_fault,
    output logic owner,
    input wire logic psw_clear,
    output logic [15:0] psw,
    output logic isw_zero,
    output logic isw_negative,
    output logic rf_rd_req,
    output logic [15:0] rf_idx,
    input wire logic [31:0] rf_rd_data,
    input wire logic rf_rd_writable,
    output logic rf_we,
    output logic [31:0] rf_wdata,
    output logic nv_req,
    output logic nv_we,
    output logic [15:0] nv_addr,
    output logic [15:0] nv_wdata,
    input wire logic [15:0] nv_rdata,
    input wire logic nv_ack,
    input wire logic nv_err,
    output logic pb_we,
    output logic [15:0] pb_addr,
    output logic [15:0] pb_wdata
);

    nvls_core_s q;
    nvls_core_s n;
    logic [1:0] gnt;
    logic busy;
    logic known;
    logic multi;
    logic is_load;
    logic [15:0] hw;
    nvls_cmd_s sel;

    // A thread whose ack is showing must not be granted again
    assign busy = (q.st != S_IDLE);

    nvls_arb u_arb (
        .clk(clk),
        .resetn(resetn),
        .req(cmd_valid & ~q.ack),
        .busy(busy),
        .gnt(gnt)
    );

    // Command decode of the granted thread
    always_comb begin
        sel = gnt[1] ? cmd1 : cmd0;
        multi = (sel.op == `NVLS_OP_MULTI_STORE);
        known = multi || (sel.op == `NVLS_OP_SINGLE_LOAD) ||
                (sel.op == `NVLS_OP_SINGLE_STORE) ||
                (sel.op == `NVLS_OP_BUF_LONG_WRITE);
        is_load = (q.op == `NVLS_OP_SINGLE_LOAD);
        hw = q.half ? rf_rd_data[31:16] : rf_rd_data[15:0];
    end

    // Next-state logic; every strobe except nv_req defaults to idle each cycle
    always_comb begin
        n = q;
        n.ack = 2'h0;
        n.fault = 1'b0;
        n.rf_rd_req = 1'b0;
        n.rf_we = 1'b0;
        n.pb_we = 1'b0;
        if (psw_clear) begin
            n.psw = 16'h0000;
        end
        unique case (q.st)
            S_IDLE: begin
                if ((gnt & cmd_valid & ~q.ack) != 2'h0) begin
                    n.owner = gnt[1];
                    n.op = sel.op;
                    // negative register number suppresses the halt
                    n.suppress = sel.rnum[15];
                    n.reg_idx = sel.rnum[15] ? -sel.rnum : sel.rnum;
                    n.addr = sel.addr;
                    n.half = 1'b0;
                    n.ck = 1'b0;
                    n.sum = 16'h0000;
                    n.err = 1'b0;
                    n.cnt = multi ? sel.count[3:0] : 4'h1;
                    n.rf_idx = n.reg_idx;
                    if (!known) begin
                        // Unknown opcode is acknowledged as a success (isw_zero set), with no access
                        n.st = S_DONE;
                    end else if (multi && (sel.count < `NVLS_MULTI_MIN ||
                                 sel.count > `NVLS_MULTI_MAX)) begin
                        n.err = 1'b1;
                        n.st = S_DONE;
                    end else if (sel.addr == 16'h0000 &&
                                 sel.op != `NVLS_OP_BUF_LONG_WRITE) begin
                        n.rf_idx = `NVLS_IND_REG;
                        n.rf_rd_req = 1'b1;
                        n.st = S_IND_WT;
                    end else begin
                        n.rf_rd_req = 1'b1;
                        n.st = (sel.op == `NVLS_OP_SINGLE_LOAD) ?
                               S_CHK_WT : S_SRC_WT;
                    end
                end
            end
            S_IND_WT: begin
                // indirect address taken from low word
                n.addr = rf_rd_data[15:0];
                n.rf_idx = q.reg_idx;
                n.rf_rd_req = 1'b1;
                n.st = is_load ? S_CHK_WT : S_SRC_WT;
            end
            S_CHK_WT: begin
                // only writable registers may be load targets
                if (!rf_rd_writable) begin
                    n.err = 1'b1;
                    n.st = S_DONE;
                end else begin
                    n.nv_req = 1'b1;
                    n.nv_we = 1'b0;
                    n.nv_addr = q.addr;
                    n.st = S_NV_RD;
                end
            end
            S_SRC_WT: begin
                if (q.op == `NVLS_OP_BUF_LONG_WRITE) begin
                    // low word first; value passed unchecked
                    n.data = rf_rd_data;
                    n.pb_we = 1'b1;
                    n.pb_addr = q.addr;
                    n.pb_wdata = rf_rd_data[15:0];
                    n.half = 1'b0;
                    n.st = S_PB_HI;
                end else begin
                    // each half sampled just before its own write
                    n.nv_req = 1'b1;
                    n.nv_we = 1'b1;
                    n.nv_addr = q.addr;
                    n.nv_wdata = hw;
                    n.sum = q.sum + hw;
                    n.st = S_NV_WR;
                end
            end
            S_NV_WR: begin
                if (nv_ack) begin
                    n.nv_req = 1'b0;
                    n.addr = q.addr + 16'h0001;
                    if (nv_err) begin
                        n.err = 1'b1;
                        n.st = S_DONE;
                    end else if (q.ck) begin
                        n.st = S_DONE;
                    end else if (!q.half) begin
                        // re-read the register for the high half
                        n.half = 1'b1;
                        n.rf_idx = q.reg_idx;
                        n.rf_rd_req = 1'b1;
                        n.st = S_SRC_WT;
                    end else if (q.cnt == 4'h1) begin
                        n.half = 1'b0;
                        n.ck = 1'b1;
                        n.nv_req = 1'b1;
                        n.nv_addr = q.addr + 16'h0001;
                        n.nv_wdata = q.sum;
                    end else begin
                        n.half = 1'b0;
                        n.cnt = q.cnt - 4'h1;
                        n.reg_idx = q.reg_idx + 16'h0001;
                        n.rf_idx = q.reg_idx + 16'h0001;
                        n.rf_rd_req = 1'b1;
                        n.st = S_SRC_WT;
                    end
                end
            end
            S_NV_RD: begin
                if (nv_ack) begin
                    n.nv_req = 1'b0;
                    n.addr = q.addr + 16'h0001;
                    if (q.ck) begin
                        // register changes only on a match
                        if (nv_rdata == q.sum) begin
                            n.rf_we = 1'b1;
                            n.rf_idx = q.reg_idx;
                            n.rf_wdata = q.data;
                        end else begin
                            n.err = 1'b1;
                        end
                        n.st = S_DONE;
                    end else begin
                        if (!q.half) begin
                            n.data[15:0] = nv_rdata;
                            n.half = 1'b1;
                        end else begin
                            n.data[31:16] = nv_rdata;
                            n.ck = 1'b1;
                        end
                        n.sum = q.sum + nv_rdata;
                        n.nv_req = 1'b1;
                        n.nv_addr = q.addr + 16'h0001;
                    end
                end
            end
            S_PB_HI: begin
                // high word into the following buffer location
                n.pb_we = 1'b1;
                n.pb_addr = q.addr + 16'h0001;
                n.pb_wdata = q.data[31:16];
                n.half = 1'b1;
                n.st = S_DONE;
            end
            S_DONE: begin
                n.ack[q.owner] = 1'b1;
                // zero on success, negative on failure
                n.isw_zero = ~q.err;
                n.isw_neg = q.err;
                n.fault = q.err & ~q.suppress;
                // failure bits win over a clear
                if (q.err) begin
                    n.psw = n.psw | `NVLS_PSW_FAIL;
                end
                n.st = S_IDLE;
            end
            default: begin
                n.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state register
    assign cmd_ack = q.ack;
    assign cmd_fault = q.fault;
    assign owner = q.owner;
    assign psw = q.psw;
    assign isw_zero = q.isw_zero;
    assign isw_negative = q.isw_neg;
    assign rf_rd_req = q.rf_rd_req;
    assign rf_idx = q.rf_idx;
    assign rf_we = q.rf_we;
    assign rf_wdata = q.rf_wdata;
    assign nv_req = q.nv_req;
    assign nv_we = q.nv_we;
    assign nv_addr = q.nv_addr;
    assign nv_wdata = q.nv_wdata;
    assign pb_we = q.pb_we;
    assign pb_addr = q.pb_addr;
    assign pb_wdata = q.pb_wdata;

    // Checks on the engine's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence seq_lo_write_done;
        nv_req && nv_we && nv_ack && !nv_err && !q.ck && !q.half;
    endsequence

    sequence seq_refused_write;
        nv_req && nv_we && nv_ack && nv_err;
    endsequence

    sequence seq_bad_checksum;
        nv_req && !nv_we && nv_ack && q.ck && (nv_rdata != q.sum);
    endsequence

    AST_ACK_ONE_THREAD: assert property (
        cmd_ack != 2'h3)
        else $error("both threads acknowledged at once");

    AST_OWNER_STABLE: assert property (
        busy && $past(busy) |-> $stable(q.owner))
        else $error("NV owner changed during a command");

    AST_INDIRECT: assert property (
        q.st == S_IND_WT |-> rf_rd_req && rf_idx == `NVLS_IND_REG
        ##1 q.addr == $past(rf_rd_data[15:0]))
        else $error("indirect address not taken from accumulator");

    AST_SPLIT_WRITE: assert property (
        seq_lo_write_done |-> ##3 (nv_req && nv_we &&
        nv_addr == $past(nv_addr, 3) + 16'h0001))
        else $error("high half did not follow the low half");

    AST_PROTECT_FLAGS: assert property (
        seq_refused_write |-> ##2 (psw[`NVLS_PSW_BIT_A] &&
        psw[`NVLS_PSW_BIT_B] && isw_negative))
        else $error("protected write did not raise status bits");

    AST_CKSUM_FLAGS: assert property (
        seq_bad_checksum |-> !rf_we [*3] ##0 (psw[`NVLS_PSW_BIT_A] &&
        psw[`NVLS_PSW_BIT_B]))
        else $error("checksum failure not flagged or data written");

    AST_SUPPRESS: assert property (
        q.st == S_DONE && q.err && q.suppress |=> !cmd_fault &&
        isw_negative && !isw_zero)
        else $error("suppressed error handled wrongly");

    AST_CKSUM_WORD: assert property (
        nv_req && nv_we && q.ck |-> nv_wdata == q.sum)
        else $error("checksum word differs from running sum");

    AST_BUF_PAIR: assert property (
        pb_we && !q.half |=> pb_we && q.half &&
        pb_addr == $past(pb_addr) + 16'h0001)
        else $error("buffer long write not two consecutive words");

    AST_DONE_ACK: assert property (
        q.st == S_DONE |=> cmd_ack[$past(q.owner)] && q.st == S_IDLE)
        else $error("command finished without an acknowledge");

endmodule
`default_nettype wire

// ### verilog/nvls_regs.svh
// Constants of the NV register load/store engine: opcodes, limits, bits.
// Assumes nothing; included by the engine and the bench by bare name.
`ifndef NVLS_REGS_SVH
`define NVLS_REGS_SVH

// Command opcodes
`define NVLS_OP_SINGLE_LOAD 8'hC7
`define NVLS_OP_MULTI_STORE 8'hC4
`define NVLS_OP_SINGLE_STORE 8'hC6
`define NVLS_OP_BUF_LONG_WRITE 8'h8A

// Accumulator register that holds an indirect NV address
`define NVLS_IND_REG 16'h000A

// Register count limits of a multi-register store
`define NVLS_MULTI_MIN 16'sh0001
`define NVLS_MULTI_MAX 16'sh000A

// Polling status word bits raised by a failed NV access
`define NVLS_PSW_BIT_A 12
`define NVLS_PSW_BIT_B 14
`define NVLS_PSW_FAIL 16'h5000

`endif

// ### verilog/nvls_pkg.sv
// Types shared by the NV register load/store engine and its arbiter.
// Assumes the constants header is on the include path.
package nvls_pkg;

    // One command as presented by a program thread
    typedef struct packed {
        logic [7:0] op;
        logic signed [15:0] count;
        logic [15:0] rnum;
        logic [15:0] addr;
    } nvls_cmd_s;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_IND_WT = 4'h1,
        S_CHK_WT = 4'h2,
        S_SRC_WT = 4'h3,
        S_NV_WR = 4'h4,
        S_NV_RD = 4'h5,
        S_PB_HI = 4'h6,
        S_DONE = 4'h7
    } nvls_state_e;

    // Whole state of the engine
    typedef struct packed {
        nvls_state_e st;
        logic [7:0] op;
        logic suppress;
        logic err;
        logic half;
        logic ck;
        logic owner;
        logic [3:0] cnt;
        logic [15:0] reg_idx;
        logic [15:0] addr;
        logic [31:0] data;
        logic [15:0] sum;
        logic [1:0] ack;
        logic fault;
        logic [15:0] psw;
        logic isw_zero;
        logic isw_neg;
        logic rf_rd_req;
        logic rf_we;
        logic [15:0] rf_idx;
        logic [31:0] rf_wdata;
        logic nv_req;
        logic nv_we;
        logic [15:0] nv_addr;
        logic [15:0] nv_wdata;
        logic pb_we;
        logic [15:0] pb_addr;
        logic [15:0] pb_wdata;
    } nvls_core_s;

    // Whole state of the thread arbiter
    typedef struct packed {
        logic [1:0] gnt;
        logic last;
    } nvls_arb_s;

endpackage

// ### verilog/nvls_arb.sv
// Two-thread arbiter for NV memory access.
// Assumes a thread holds its request until acknowledged; busy is high
// while the engine works on the granted command.
`timescale 1ns/1ps
`default_nettype none
module nvls_arb
    import nvls_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] req,
    input wire logic busy,
    output logic [1:0] gnt
);

    nvls_arb_s q;
    nvls_arb_s n;

    // Grant sticks while busy or still requested, so it never flips
    // under a command in flight; fresh ties alternate between threads
    always_comb begin
        n = q;
        if (!busy) begin
            if ((q.gnt & req) == 2'h0) begin
                n.gnt = 2'h0;
                if (req == 2'h3) begin
                    n.gnt = q.last ? 2'h1 : 2'h2;
                    n.last = ~q.last;
                end else if (req[0]) begin
                    n.gnt = 2'h1;
                    n.last = 1'b0;
                end else if (req[1]) begin
                    n.gnt = 2'h2;
                    n.last = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign gnt = q.gnt;

endmodule
`default_nettype wire

// ### verif/nvls_nv_model.sv
// Behavioural NV word array and register file facing the engine.
// Assumes the bench presets both arrays by hierarchical reference.
`timescale 1ns/1ps
`default_nettype none
module nvls_nv_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic nv_req,
    input wire logic nv_we,
    input wire logic [15:0] nv_addr,
    input wire logic [15:0] nv_wdata,
    output logic [15:0] nv_rdata,
    output logic nv_ack,
    output logic nv_err,
    input wire logic rf_rd_req,
    input wire logic [15:0] rf_idx,
    output logic [31:0] rf_rd_data,
    output logic rf_rd_writable,
    input wire logic rf_we,
    input wire logic [31:0] rf_wdata
);
    logic [15:0] nv [0:255];
    logic [31:0] regs [0:255];
    logic [2:0] wt;
    logic [7:0] ri;
    // Outside a read the lines show inverted data, never the last value
    assign ri = rf_idx[7:0];
    assign rf_rd_data = rf_rd_req ? regs[ri] : ~regs[ri];
    assign rf_rd_writable = (ri != 8'h05) ^ !rf_rd_req;
    initial begin
        nv_ack = 1'b0;
        nv_err = 1'b0;
        nv_rdata = 16'h0000;
        wt = 3'h0;
    end
    // One answer per request; slow mode waits three extra cycles
    always @(posedge clk) begin
        nv_err <= 1'b0;
        nv_rdata <= ~nv_rdata;
        if (rf_we) begin
            regs[ri] <= rf_wdata;
        end
        if (nv_ack || !nv_req) begin
            nv_ack <= 1'b0;
            wt <= 3'h0;
        end else if (wt >= (slow ? 3'h3 : 3'h0)) begin
            nv_ack <= 1'b1;
            // Words from 0xF0 up refuse writes
            nv_err <= nv_we && nv_addr[7:0] >= 8'hF0;
            if (nv_we && nv_addr[7:0] < 8'hF0) begin
                nv[nv_addr[7:0]] <= nv_wdata;
            end
            if (!nv_we) begin
                nv_rdata <= nv[nv_addr[7:0]];
            end
        end else begin
            wt <= wt + 3'h1;
        end
    end
endmodule
`default_nettype wire

// ### verif/nvls_engine_tb.sv
// Self-checking bench of the NV load/store engine.
// Assumes the NV and register-file model and the constants header.
`timescale 1ns/1ps
`default_nettype none
`include "nvls_regs.svh"
module nvls_engine_tb;
    import nvls_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic slow = 1'b0;
    logic psw_clear = 1'b0;
    logic [1:0] cmd_valid = 2'b00;
    nvls_cmd_s cmd0 = '0;
    nvls_cmd_s cmd1 = '0;
    logic [1:0] cmd_ack;
    logic cmd_fault, owner, isw_zero, isw_negative, rf_rd_req, rf_we;
    logic rf_rd_writable, nv_req, nv_we, nv_ack, nv_err, pb_we, flt;
    logic [15:0] psw, rf_idx, nv_addr, nv_wdata, nv_rdata, pb_addr;
    logic [15:0] pb_wdata;
    logic [15:0] pbuf [0:255];
    logic [31:0] rf_wdata, rf_rd_data;
    int error_cnt = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    nvls_engine dut_u (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd0(cmd0), .cmd1(cmd1), .cmd_ack(cmd_ack), .cmd_fault(cmd_fault),
        .owner(owner), .psw_clear(psw_clear), .psw(psw),
        .isw_zero(isw_zero), .isw_negative(isw_negative),
        .rf_rd_req(rf_rd_req), .rf_idx(rf_idx), .rf_rd_data(rf_rd_data),
        .rf_rd_writable(rf_rd_writable), .rf_we(rf_we),
        .rf_wdata(rf_wdata), .nv_req(nv_req), .nv_we(nv_we),
        .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata),
        .nv_ack(nv_ack), .nv_err(nv_err), .pb_we(pb_we),
        .pb_addr(pb_addr), .pb_wdata(pb_wdata));
    nvls_nv_model mdl_u (.clk(clk), .slow(slow), .nv_req(nv_req),
        .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
        .nv_rdata(nv_rdata), .nv_ack(nv_ack), .nv_err(nv_err),
        .rf_rd_req(rf_rd_req), .rf_idx(rf_idx), .rf_rd_data(rf_rd_data),
        .rf_rd_writable(rf_rd_writable), .rf_we(rf_we),
        .rf_wdata(rf_wdata));
    // Program buffer image, filled from the engine's buffer writes
    always @(posedge clk) begin
        if (pb_we) begin
            pbuf[pb_addr[7:0]] <= pb_wdata;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic nvls_cmd_s mk(logic [7:0] o, logic [15:0] n,
        logic [15:0] r, logic [15:0] a);
        return '{op: o, count: n, rnum: r, addr: a};
    endfunction
    // Issue on one thread, wait for its ack, then drop the request
    task automatic do_cmd(input logic t, input nvls_cmd_s c);
        int n;
        n = 0;
        @(posedge clk);
        if (t) cmd1 <= c;
        else cmd0 <= c;
        cmd_valid[t] <= 1'b1;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (cmd_ack[t] !== 1'b1 && n < 500);
        flt = cmd_fault;
        chk(owner, t);
        chk({31'h0, n >= 500}, 32'h0);
        @(posedge clk);
        cmd_valid[t] <= 1'b0;
        #1;
    endtask
    task automatic clr_psw();
        @(posedge clk);
        psw_clear <= 1'b1;
        @(posedge clk);
        psw_clear <= 1'b0;
        #1;
        chk(psw, 16'h0000);
    endtask
    task automatic t_store_load();
        mdl_u.regs[3] = 32'h1234ABCD;
        // Store of a writable register to a plain address
        do_cmd(1'b0, mk(`NVLS_OP_SINGLE_STORE, 16'h0001, 16'h0003, 16'h0040));
        chk({mdl_u.nv[8'h41], mdl_u.nv[8'h40]}, 32'h1234ABCD);
        chk(mdl_u.nv[8'h42], 16'hBE01);
        chk({flt, isw_zero, isw_negative, psw}, {3'b010, 16'h0000});
        // Load back what a single store left
        do_cmd(1'b1, mk(`NVLS_OP_SINGLE_LOAD, 16'h0001, 16'h0014, 16'h0040));
        chk(mdl_u.regs[20], 32'h1234ABCD);
        chk({flt, isw_zero, psw}, {2'b01, 16'h0000});
        mdl_u.nv[8'h42] = 16'hBE02;
        mdl_u.regs[21] = 32'h0BAD0BAD;
        do_cmd(1'b0, mk(`NVLS_OP_SINGLE_LOAD, 16'h0001, 16'h0015, 16'h0040));
        chk(mdl_u.regs[21], 32'h0BAD0BAD);
        chk({flt, isw_negative, psw}, {2'b11, `NVLS_PSW_FAIL});
        clr_psw();
        // Register five refuses writes, so the load must fail
        do_cmd(1'b0, mk(`NVLS_OP_SINGLE_LOAD, 16'h0001, 16'h0005, 16'h0040));
        chk({flt, isw_negative}, 2'b11);
        clr_psw();
    endtask
    task automatic t_indirect();
        mdl_u.regs[10] = 32'hFFFF0060;
        mdl_u.regs[7] = 32'h00020003;
        slow <= 1'b1;
        do_cmd(1'b1, mk(`NVLS_OP_SINGLE_STORE, 16'h0001, 16'h0007, 16'h0000));
        chk({mdl_u.nv[8'h62], mdl_u.nv[8'h61]}, 32'h00050002);
        chk(mdl_u.nv[8'h60], 16'h0003);
        slow <= 1'b0;
    endtask
    task automatic t_multi();
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < 10; i++) begin
            mdl_u.regs[10 + i] = {16'hA000 + 16'(i), 16'hF00F + 16'(i)};
        end
        // Sources stay in registers 10 to 19
        do_cmd(1'b0, mk(`NVLS_OP_MULTI_STORE, `NVLS_MULTI_MAX, 16'h000A,
            16'h0080));
        for (int i = 0; i < 10; i++) begin
            chk({mdl_u.nv[8'h81 + 2 * i], mdl_u.nv[8'h80 + 2 * i]},
                mdl_u.regs[10 + i]);
            s = s + mdl_u.regs[10 + i][31:16] + mdl_u.regs[10 + i][15:0];
        end
        chk(mdl_u.nv[8'h94], s);
        chk({flt, psw}, {1'b0, 16'h0000});
        // Counts just outside 1..10 are refused
        do_cmd(1'b1, mk(`NVLS_OP_MULTI_STORE, 16'h000B, 16'h000A, 16'h00A0));
        chk({flt, isw_negative}, 2'b11);
        do_cmd(1'b0, mk(`NVLS_OP_MULTI_STORE, 16'h0000, 16'h000A, 16'h00A0));
        chk({flt, isw_negative}, 2'b11);
        clr_psw();
    endtask
    task automatic t_protect();
        // Plain register number: the fault halts the thread
        do_cmd(1'b0, mk(`NVLS_OP_SINGLE_STORE, 16'h0001, 16'h0003, 16'h00F0));
        chk({flt, isw_negative, psw}, {2'b11, `NVLS_PSW_FAIL});
        clr_psw();
        // Negative register number keeps the program going
        do_cmd(1'b1, mk(`NVLS_OP_SINGLE_STORE, 16'h0001, 16'hFFFD, 16'h00F2));
        chk({flt, isw_negative, psw}, {2'b01, `NVLS_PSW_FAIL});
        clr_psw();
    endtask
    task automatic t_buffer();
        mdl_u.regs[9] = 32'hFFFF8000;
        do_cmd(1'b1, mk(`NVLS_OP_BUF_LONG_WRITE, 16'h0001, 16'h0009,
            16'h007A));
        chk({pbuf[8'h7B], pbuf[8'h7A]}, 32'hFFFF8000);
        chk(psw, 16'h0000);
    endtask
    task automatic t_arb();
        int n;
        int a0;
        int a1;
        logic [1:0] seen;
        n = 0;
        a0 = 0;
        a1 = 0;
        seen = 2'b00;
        mdl_u.regs[30] = 32'h11112222;
        mdl_u.regs[31] = 32'h33334444;
        @(posedge clk);
        cmd0 <= mk(`NVLS_OP_SINGLE_STORE, 16'h0001, 16'h001E, 16'h00C0);
        cmd1 <= mk(`NVLS_OP_SINGLE_STORE, 16'h0001, 16'h001F, 16'h00C8);
        cmd_valid <= 2'b11;
        // One edge per pass, so a one-cycle ack is never skipped
        do begin
            @(posedge clk);
            cmd_valid <= cmd_valid & ~seen;
            #1;
            n++;
            seen = cmd_ack;
            chk({31'h0, seen == 2'b11}, 32'h0);
            a0 += int'(seen[0]);
            a1 += int'(seen[1]);
        end while (cmd_valid !== 2'b00 && n < 500);
        chk({31'h0, n >= 500}, 32'h0);
        chk({a0[3:0], a1[3:0]}, 8'h11);
        chk({mdl_u.nv[8'hC1], mdl_u.nv[8'hC9]}, 32'h11113333);
    endtask
    // Cut a hang short
    initial begin
        #400000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk({cmd_ack, nv_req, rf_we, psw}, 20'h00000);
        t_store_load();
        t_indirect();
        t_multi();
        t_protect();
        t_buffer();
        t_arb();
        complete_run();
    end
endmodule
`default_nettype wire
